// >>> logic/clock_freeze_defines.vh
`ifndef CLOCK_FREEZE_DEFINES_VH
`define CLOCK_FREEZE_DEFINES_VH

// APB register byte offsets
`define CTRL_OFFSET         8'h00
`define MASK_OFFSET         8'h04
`define STATUS_OFFSET       8'h08

// Control register fields
`define CTRL_BUS_DIV_LSB    0
`define CTRL_BUS_DIV_MSB    1
`define CTRL_PERI_DIV_LSB   2
`define CTRL_PERI_DIV_MSB   3
`define CTRL_RESET          4'h0
`define DIV_RESET           2'h0

// Status register fields
`define STATUS_RUN_LSB      0
`define STATUS_RUN_MSB      14
`define STATUS_BUSY_BIT     16

// Freeze mask and outputs
`define MASK_BITS           13
`define NUM_OUTPUTS         15
`define MASK_RESET          13'h1FFF
`define WANT_RESET          15'h7FFF
`define MASK_LAST_INDEX     4'hC

// Output index map
`define IDX_DOUBLE          0
`define IDX_PROC_QUAL       1
`define IDX_BUS_QUAL        2
`define IDX_BUS_FIRST       13
`define IDX_PERI_FIRST      14

// Processor clock period in pclk cycles
`define PROC_PERIOD_CYCLES  3'h4

`endif

// >>> logic/clock_gate_cell.v
module clock_gate_cell
(
   input  wire pclk,
   input  wire presetn,
   input  wire raw_clk,
   input  wire want_run,
   output reg  gated_clk,
   output reg  running
);

   // Enable changes only while the raw clock is low, so high phases stay whole
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         running   <= 1'b1;
         gated_clk <= 1'b0;
      end
      else
      begin
         if (!raw_clk)
         begin
            running <= want_run;
         end
         gated_clk <= raw_clk & running;
      end
   end

endmodule // clock_gate_cell

// >>> logic/clock_output_freeze_control.v
`include "clock_freeze_defines.vh"

//Contract
// - Thirteen-bit serial mask, one bit per output.
// - First bus and peripheral clocks never masked.
// - Mask bit 0 freezes, 1 unfreezes.
// - Frozen output stays low.
// - Strobe with low level freezes all fifteen.
// - Strobe with high level unfreezes all fifteen.
// - Freeze only after natural falling edge.
// - Unfreeze only during natural low phase.
// - One bit per shift clock, rising sampled.
// - Mask bits map to named outputs.
// - Unfreeze strobe restarts mask-frozen outputs.
// - Processor qualifier half double clock rate.
// - Bus qualifier ratio 1, 1/2, 1/3, 1/4.
// - Bus qualifier duty 66/33 and 75/25.
module clock_output_freeze_control
#(
   parameter MASK_WIDTH = `MASK_BITS,
   parameter OUT_COUNT  = `NUM_OUTPUTS
)
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output wire        pready,
   output wire        pslverr,
   input  wire        freeze_data,
   input  wire        freeze_shift_clock,
   input  wire        freeze_strobe_n,
   input  wire        common_freeze_level,
   output wire        processor_double_clock,
   output wire        processor_clock_qualifier,
   output wire        bus_clock_qualifier,
   output wire        first_bus_clock,
   output wire [3:0]  bus_clocks_one_to_four,
   output wire        first_peripheral_bus_clock,
   output wire [5:0]  peripheral_bus_clocks_one_to_six
);

   localparam ST_IDLE  = 1'b0;
   localparam ST_SHIFT = 1'b1;

   reg  [3:0]            ctrl_r;
   reg  [MASK_WIDTH-1:0] mask_r;
   reg  [MASK_WIDTH-1:0] shift_r;
   reg  [3:0]            bit_cnt_r;
   reg                   rx_state_r;
   reg                   shift_clk_prev_r;
   reg                   strobe_prev_r;
   reg  [OUT_COUNT-1:0]  want_r;
   reg  [1:0]            phase_r;
   reg  [1:0]            bus_cnt_r;
   reg  [1:0]            peri_cnt_r;
   reg  [1:0]            bus_div_r;
   reg  [1:0]            peri_div_r;

   wire                  shift_edge;
   wire                  strobe_fall;
   wire                  frame_done;
   wire [MASK_WIDTH-1:0] mask_nxt;
   wire [OUT_COUNT-1:0]  raw_clk;
   wire [OUT_COUNT-1:0]  gated_clk;
   wire [OUT_COUNT-1:0]  running;
   wire                  wr_en;
   wire                  rd_setup;
   wire                  addr_hit;
   wire [2:0]            bus_ratio;
   reg  [1:0]            peri_ratio;
   wire [3:0]            bus_pos;
   wire [3:0]            bus_half;
   wire [5:0]            bus_period;
   wire [5:0]            bus_half6;
   reg  [5:0]            peri_base;
   wire [5:0]            peri_half;
   wire [5:0]            peri_pos;
   wire                  double_raw;
   wire                  proc_qual_raw;
   wire                  bus_raw;
   wire                  bus_qual_raw;
   wire                  peri_raw;
   wire                  phase_wrap;
   wire                  bus_wrap;
   wire                  peri_wrap;

   // APB slave, zero wait states
   assign pready   = 1'b1;
   assign addr_hit = (paddr == `CTRL_OFFSET) || (paddr == `MASK_OFFSET) ||
                     (paddr == `STATUS_OFFSET);
   assign pslverr  = psel & penable & ~addr_hit;
   assign wr_en    = psel & penable & pwrite & addr_hit;
   assign rd_setup = psel & ~penable & ~pwrite;

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_r <= `CTRL_RESET;
      end
      else if (wr_en && (paddr == `CTRL_OFFSET) && pstrb[0])
      begin
         ctrl_r <= pwdata[`CTRL_PERI_DIV_MSB:`CTRL_BUS_DIV_LSB];
      end
   end

   // Read data captured in setup so it is a flop output in the access phase
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h0000_0000;
      end
      else if (rd_setup)
      begin
         case (paddr)
            `CTRL_OFFSET:
            begin
               prdata <= {28'h000_0000, ctrl_r};
            end
            `MASK_OFFSET:
            begin
               prdata <= {19'h0_0000, mask_r};
            end
            `STATUS_OFFSET:
            begin
               prdata <= {15'h0000, rx_state_r, 1'b0, running};
            end
            default:
            begin
               prdata <= 32'h0000_0000;
            end
         endcase
      end
   end

   // Serial mask receiver; shift clock is sampled, not used as a clock
   assign shift_edge = freeze_shift_clock & ~shift_clk_prev_r;
   assign strobe_fall = strobe_prev_r & ~freeze_strobe_n;
   assign mask_nxt   = {freeze_data, shift_r[MASK_WIDTH-1:1]};
   assign frame_done = shift_edge && (rx_state_r == ST_SHIFT) &&
                       (bit_cnt_r == `MASK_LAST_INDEX);

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         shift_clk_prev_r <= 1'b0;
         strobe_prev_r    <= 1'b1;
      end
      else
      begin
         shift_clk_prev_r <= freeze_shift_clock;
         strobe_prev_r    <= freeze_strobe_n;
      end
   end

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_state_r <= ST_IDLE;
         bit_cnt_r  <= 4'h0;
         shift_r    <= `MASK_RESET;
         mask_r     <= `MASK_RESET;
      end
      else if (shift_edge)
      begin
         case (rx_state_r)
            ST_IDLE:
            begin
               // Idle line is high; a low sample is the start bit
               if (!freeze_data)
               begin
                  rx_state_r <= ST_SHIFT;
                  bit_cnt_r  <= 4'h0;
               end
            end
            ST_SHIFT:
            begin
               // First bit received lands in bit 0
               shift_r   <= mask_nxt;
               bit_cnt_r <= bit_cnt_r + 4'h1;
               if (frame_done)
               begin
                  mask_r     <= mask_nxt;
                  rx_state_r <= ST_IDLE;
               end
            end
            default:
            begin
               rx_state_r <= ST_IDLE;
            end
         endcase
      end
   end

   // Per-output run request; strobe overrides a mask landing in the same cycle
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         want_r <= `WANT_RESET;
      end
      else if (strobe_fall)
      begin
         want_r <= {OUT_COUNT{common_freeze_level}};
      end
      else if (frame_done)
      begin
         // Top two outputs are outside the mask reach
         want_r[MASK_WIDTH-1:0] <= mask_nxt;
      end
   end

   // Clock phase generation; dividers switch only at a common wrap
   assign bus_ratio  = {1'b0, bus_div_r} + 3'h1;

   // Divider code 3 follows the processor qualifier; its default ratio of 1 only times the wrap
   always @*
   begin
      case (peri_div_r)
         2'h1:
         begin
            peri_ratio = 2'h2;
         end
         2'h2:
         begin
            peri_ratio = 2'h3;
         end
         default:
         begin
            peri_ratio = 2'h1;
         end
      endcase
   end

   assign phase_wrap = (phase_r == 2'h3);
   assign bus_wrap   = phase_wrap && (bus_cnt_r == bus_div_r);
   assign peri_wrap  = bus_wrap && (peri_cnt_r == (peri_ratio - 2'h1));

   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase_r    <= 2'h0;
         bus_cnt_r  <= 2'h0;
         peri_cnt_r <= 2'h0;
         bus_div_r  <= `DIV_RESET;
         peri_div_r <= `DIV_RESET;
      end
      else
      begin
         phase_r <= phase_r + 2'h1;
         if (bus_wrap)
         begin
            bus_cnt_r <= 2'h0;
         end
         else if (phase_wrap)
         begin
            bus_cnt_r <= bus_cnt_r + 2'h1;
         end
         if (peri_wrap)
         begin
            peri_cnt_r <= 2'h0;
            // Switching mid-period would give odd-length pulses
            bus_div_r  <= ctrl_r[`CTRL_BUS_DIV_MSB:`CTRL_BUS_DIV_LSB];
            peri_div_r <= ctrl_r[`CTRL_PERI_DIV_MSB:`CTRL_PERI_DIV_LSB];
         end
         else if (bus_wrap)
         begin
            peri_cnt_r <= peri_cnt_r + 2'h1;
         end
      end
   end

   assign double_raw    = ~phase_r[0];
   assign proc_qual_raw = ~phase_r[1];
   assign bus_pos       = {bus_cnt_r, phase_r};
   assign bus_half      = {bus_ratio, 1'b0};
   assign bus_raw       = (bus_pos < bus_half);
   assign bus_qual_raw  = bus_div_r[1] ? (bus_cnt_r < bus_div_r) : bus_raw;

   assign bus_period = {1'b0, bus_ratio, 2'b00};
   assign bus_half6  = {2'b00, bus_half};

   // Offset of the current bus period inside the peripheral period
   always @*
   begin
      case (peri_cnt_r)
         2'h0:
         begin
            peri_base = 6'h00;
         end
         2'h1:
         begin
            peri_base = bus_period;
         end
         default:
         begin
            peri_base = {bus_period[4:0], 1'b0};
         end
      endcase
   end

   assign peri_half  = (peri_ratio == 2'h1) ? bus_half6 :
                       (peri_ratio == 2'h2) ? {bus_half6[4:0], 1'b0} :
                       bus_half6 + {bus_half6[4:0], 1'b0};
   assign peri_pos   = peri_base + {2'b00, bus_pos};
   assign peri_raw   = (peri_div_r == 2'h3) ? proc_qual_raw : (peri_pos < peri_half);

   // Output index order matches mask bit order
   assign raw_clk[`IDX_DOUBLE]     = double_raw;
   assign raw_clk[`IDX_PROC_QUAL]  = proc_qual_raw;
   assign raw_clk[`IDX_BUS_QUAL]   = bus_qual_raw;
   assign raw_clk[6:3]             = {4{bus_raw}};
   assign raw_clk[12:7]            = {6{peri_raw}};
   assign raw_clk[`IDX_BUS_FIRST]  = bus_raw;
   assign raw_clk[`IDX_PERI_FIRST] = peri_raw;

   genvar gi;
   generate
      for (gi = 0; gi < OUT_COUNT; gi = gi + 1)
      begin : g_gate
         clock_gate_cell u_gate
         (
            .pclk      (pclk),
            .presetn   (presetn),
            .raw_clk   (raw_clk[gi]),
            .want_run  (want_r[gi]),
            .gated_clk (gated_clk[gi]),
            .running   (running[gi])
         );
      end
   endgenerate

   assign processor_double_clock           = gated_clk[`IDX_DOUBLE];
   assign processor_clock_qualifier        = gated_clk[`IDX_PROC_QUAL];
   assign bus_clock_qualifier              = gated_clk[`IDX_BUS_QUAL];
   assign bus_clocks_one_to_four           = gated_clk[6:3];
   assign peripheral_bus_clocks_one_to_six = gated_clk[12:7];
   assign first_bus_clock                  = gated_clk[`IDX_BUS_FIRST];
   assign first_peripheral_bus_clock       = gated_clk[`IDX_PERI_FIRST];

endmodule // clock_output_freeze_control

// >>> sim/clock_freeze_monitor.sv
module clock_freeze_monitor
(
   input wire       pclk,
   input wire       presetn,
   input wire       psel,
   input wire       penable,
   input wire [7:0] paddr,
   input wire       pready,
   input wire       pslverr,
   input wire       freeze_strobe_n,
   input wire       common_freeze_level,
   input wire       processor_double_clock,
   input wire       processor_clock_qualifier,
   input wire       bus_clock_qualifier
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_ready; pready; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_err;
      pslverr == (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08}));
   endproperty
   a_err: assert property (p_err) else $error("pslverr wrong");
   property p_dbl; $rose(processor_double_clock) |=> !processor_double_clock; endproperty
   a_dbl: assert property (p_dbl) else $error("double clock high width");
   property p_pq; $rose(processor_clock_qualifier) |=> processor_clock_qualifier ##1
      !processor_clock_qualifier; endproperty
   a_pq: assert property (p_pq) else $error("qualifier high width");
   property p_pq_lo; $fell(processor_clock_qualifier) |=> !processor_clock_qualifier; endproperty
   a_pq_lo: assert property (p_pq_lo) else $error("qualifier low width");
   property p_bq; $rose(bus_clock_qualifier) |=> bus_clock_qualifier; endproperty
   a_bq: assert property (p_bq) else $error("bus qualifier runt high");
   property p_bq_lo; $fell(bus_clock_qualifier) |=> !bus_clock_qualifier; endproperty
   a_bq_lo: assert property (p_bq_lo) else $error("bus qualifier runt low");
   property p_frz; ($fell(freeze_strobe_n) && !common_freeze_level) |-> ##6
      (!processor_double_clock && !processor_clock_qualifier) [*8]; endproperty
   a_frz: assert property (p_frz) else $error("strobe did not freeze");
   property p_run; ($fell(freeze_strobe_n) && common_freeze_level) |->
      ##[1:8] $rose(processor_double_clock); endproperty
   a_run: assert property (p_run) else $error("strobe did not unfreeze");
endmodule // clock_freeze_monitor

bind clock_output_freeze_control clock_freeze_monitor mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
   .freeze_strobe_n(freeze_strobe_n), .common_freeze_level(common_freeze_level),
   .processor_double_clock(processor_double_clock),
   .processor_clock_qualifier(processor_clock_qualifier),
   .bus_clock_qualifier(bus_clock_qualifier));

// >>> sim/freeze_controller_model.sv
module freeze_controller_model
(
   output logic freeze_data,
   output logic freeze_shift_clock,
   output logic freeze_strobe_n,
   output logic common_freeze_level
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      freeze_data = 1'b1;
      freeze_shift_clock = 1'b0;
      freeze_strobe_n = 1'b1;
      common_freeze_level = 1'b1;
   end
   // Free running; this half period never lands on a pclk rising edge
   always #18.4 freeze_shift_clock = ~freeze_shift_clock;
   // Data moves on falling edge, so it is steady at the rising edge
   task automatic send(input logic [12:0] m);
      integer i;
      @(negedge freeze_shift_clock) freeze_data = 1'b0;
      for (i = 0; i < 13; i++) @(negedge freeze_shift_clock) freeze_data = m[i];
      @(negedge freeze_shift_clock) freeze_data = 1'b1;
   endtask
   task automatic strobe(input logic level);
      // Offsets keep every change away from pclk rising edges
      #3 common_freeze_level = level;
      #20 freeze_strobe_n = 1'b0;
      #30 freeze_strobe_n = 1'b1;
      #25;
   endtask
endmodule // freeze_controller_model

// >>> sim/test_clock_output_freeze_control.sv
`include "clock_freeze_defines.vh"
module test_clock_output_freeze_control;
   timeunit 1ns;
   timeprecision 1ps;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rd;
   logic        er;
   wire  [31:0] prdata;
   wire         pready, pslverr, sdat, sclk, stb_n, lvl, dbl, pq, bq, bc0, pc0;
   wire  [3:0]  bcs;
   wire  [5:0]  pcs;
   wire  [3:0]  obs = {pc0, bc0, bq, pq};
   integer      miscompares = 0;
   integer      n_compared = 0;
   always #5 pclk = ~pclk;
   freeze_controller_model ctl (.freeze_data(sdat), .freeze_shift_clock(sclk),
      .freeze_strobe_n(stb_n), .common_freeze_level(lvl));
   clock_output_freeze_control DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .freeze_data(sdat),
      .freeze_shift_clock(sclk), .freeze_strobe_n(stb_n), .common_freeze_level(lvl),
      .processor_double_clock(dbl), .processor_clock_qualifier(pq),
      .bus_clock_qualifier(bq), .first_bus_clock(bc0), .bus_clocks_one_to_four(bcs),
      .first_peripheral_bus_clock(pc0), .peripheral_bus_clocks_one_to_six(pcs));
   task automatic summarize;
      if (miscompares == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      integer n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (n = 0; pready !== 1'b1 && n < 20; n++) @(posedge pclk);
      if (n == 20)
      begin
         miscompares++;
         summarize;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Sampled on the falling edge, where registered outputs have settled
   task automatic settle(input logic [31:0] st, input logic [12:0] run, input logic [1:0] fix);
      logic [12:0] acc;
      logic [1:0]  acc2;
      acc = 13'h0000;
      acc2 = 2'h0;
      repeat (30) @(posedge pclk);
      apb(1'b0, `STATUS_OFFSET, 32'h0);
      chk("status", rd, st);
      repeat (16) @(negedge pclk) {acc, acc2} = {acc | {pcs, bcs, bq, pq, dbl}, acc2 | {pc0, bc0}};
      chk("outputs", {19'h0, acc}, {19'h0, run});
      chk("fixed", {30'h0, acc2}, {30'h0, fix});
   endtask
   task automatic meas(input integer k, output integer hi, output integer lo);
      integer n, m;
      for (n = 0; obs[k] !== 1'b0 && n < 200; n++) @(negedge pclk);
      for (m = 0; obs[k] !== 1'b1 && m < 200; m++) @(negedge pclk);
      if (n == 200 || m == 200)
      begin
         miscompares++;
         summarize;
      end
      for (hi = 0; obs[k] === 1'b1 && hi < 100; hi++) @(negedge pclk);
      for (lo = 0; obs[k] === 1'b0 && lo < 100; lo++) @(negedge pclk);
   endtask
   task automatic t_reset;
      repeat (10) @(posedge pclk);
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      chk("ctrl", rd, 32'h0);
      apb(1'b0, `STATUS_OFFSET, 32'h0);
      chk("status", rd, 32'h7FFF);
      apb(1'b1, `MASK_OFFSET, 32'h0);
      apb(1'b0, `MASK_OFFSET, 32'h0);
      chk("mask", rd, 32'h1FFF);
      apb(1'b0, 8'h0C, 32'h0);
      chk("unmapped", {er, rd[30:0]}, 32'h80000000);
   endtask
   task automatic t_map;
      integer i;
      for (i = 0; i < 13; i++)
      begin
         ctl.send(13'h0001 << i);
         settle(32'h6000 | (32'h1 << i), 13'h0001 << i, 2'h3);
         apb(1'b0, `MASK_OFFSET, 32'h0);
         chk("mask", rd, 32'h1 << i);
      end
   endtask
   // Reads land mid-frame: the old mask must still stand
   task automatic t_partial;
      fork
         ctl.send(13'h0000);
         begin
            repeat (25) @(posedge pclk);
            apb(1'b0, `STATUS_OFFSET, 32'h0);
            chk("busy", {31'h0, rd[16]}, 32'h1);
            apb(1'b0, `MASK_OFFSET, 32'h0);
            chk("mask", rd, 32'h1000);
         end
      join
      settle(32'h6000, 13'h0000, 2'h3);
   endtask
   task automatic t_strobe;
      ctl.strobe(1'b0);
      settle(32'h0, 13'h0000, 2'h0);
      ctl.strobe(1'b1);
      settle(32'h7FFF, 13'h1FFF, 2'h3);
   endtask
   task automatic t_div;
      integer d, hi, lo;
      integer hx [0:3] = '{2, 4, 8, 12};
      integer px [0:3] = '{4, 8, 12, 2};
      for (d = 0; d < 4; d++)
      begin
         apb(1'b1, `CTRL_OFFSET, d);
         repeat (100) @(posedge pclk);
         apb(1'b0, `CTRL_OFFSET, 32'h0);
         chk("ctrl", rd, d);
         meas(1, hi, lo);
         chk("bq high", hi, hx[d]);
         chk("bq low", lo, (d == 0) ? 2 : 4);
         meas(2, hi, lo);
         chk("bus period", hi + lo, 4 * (d + 1));
         meas(0, hi, lo);
         chk("pq high", hi, 2);
         chk("pq low", lo, 2);
      end
      // Bus divider at two, every peripheral divider code in turn
      for (d = 0; d < 4; d++)
      begin
         apb(1'b1, `CTRL_OFFSET, 4 * d + 1);
         repeat (100) @(posedge pclk);
         meas(3, hi, lo);
         chk("peri high", hi, px[d]);
         chk("peri low", lo, px[d]);
      end
   endtask
   initial
   begin
      #300us;
      miscompares++;
      summarize;
   end
   initial
   begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_map;
      t_partial;
      t_strobe;
      t_div;
      summarize;
   end
endmodule // test_clock_output_freeze_control
